//--- mpbs_pkg.sv
// package: constants and types of the motion program block sequencer
package mpbs_pkg;
  localparam int unsigned NUM_BLOCKS      = 16;
  localparam int unsigned IDX_W           = 4;
  localparam int unsigned PARAM_W         = 16;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned MS_CYCLES       = CLK_HZ / MS_PER_S;
  localparam int unsigned MS_CNT_W        = 17;
  localparam logic [2:0]  OPSEL_PROGRAM   = 3'h6;
  localparam int unsigned STW2_OUT1_BIT   = 10;
  localparam int unsigned STW2_OUT2_BIT   = 11;
  localparam logic [15:0] WARN_EXT_WAIT   = 16'h0550;
  localparam logic [1:0]  OUT_SEL_ONE     = 2'h1;
  localparam logic [1:0]  OUT_SEL_TWO     = 2'h2;
  localparam logic [1:0]  OUT_SEL_BOTH    = 2'h3;
  localparam int unsigned EXT_SRC_W       = 2;

  typedef enum logic [2:0] {
    MODE_RESET_IO = 3'b000,
    MODE_POSITION = 3'b001,
    MODE_STOPPER  = 3'b010,
    MODE_FWD      = 3'b011,
    MODE_REV      = 3'b100,
    MODE_WAIT     = 3'b101,
    MODE_SWITCH   = 3'b110,
    MODE_SET_IO   = 3'b111
  } mpbs_mode_t;

  typedef enum logic [2:0] {
    COND_FINISH    = 3'b000,
    COND_INTERMIT  = 3'b001,
    COND_CONTINUE  = 3'b010,
    COND_EXT_EXEC  = 3'b011,
    COND_EXT_WAIT  = 3'b100,
    COND_EXT_ALARM = 3'b101
  } mpbs_cond_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN  = 3'b001,
    ST_STOP = 3'b010,
    ST_EXTW = 3'b011,
    ST_NEXT = 3'b100
  } mpbs_state_t;
endpackage : mpbs_pkg

//--- mpbs_sequencer.sv
// module: program block sequencer steering the motion core
//
// What this block does
// RULE_01: each block holds a task mode code 1..7 plus a reset-outputs mode.
// RULE_02: fixed stopper drives to the stop and completes on torque reached.
// RULE_03: forward cycle turns positive, reverse cycle turns negative.
// RULE_04: waiting holds for the block's time in milliseconds.
// RULE_05: switching jumps to the block index held in the parameter field.
// RULE_06: set-outputs with parameter 1, 2 or 3 sets output one, two or both.
// RULE_07: reset-outputs with parameter 1, 2 or 3 clears one, two or both.
// RULE_08: a finish condition stops the sequence after that block.
// RULE_09: intermittent waits for standstill at target before the next block.
// RULE_10: continuous starts the next block without deceleration.
// RULE_11: a source-select input picks the external execution signal.
// RULE_12: external execution acts as continuous but jumps early on a trigger.
// RULE_13: external wait pauses after the block until the signal reads 1.
// RULE_14: external alarm waits likewise and flags a warning while waiting.
// RULE_15: the host selects program mode, sets the index, then gives an edge.
// RULE_16: sixteen blocks, run in index order unless a switch redirects.
`timescale 1ns/1ps
`default_nettype none
module mpbs_sequencer
  import mpbs_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [2:0]            positioning_operation_select,
  input  wire logic [mpbs_pkg::IDX_W-1:0] block_select,
  input  wire logic                  block_launch_trigger,
  input  wire logic                  tbl_wr,
  input  wire logic [mpbs_pkg::IDX_W-1:0] tbl_wr_idx,
  input  wire mpbs_pkg::mpbs_mode_t  tbl_wr_mode,
  input  wire mpbs_pkg::mpbs_cond_t  tbl_wr_cond,
  input  wire logic [mpbs_pkg::PARAM_W-1:0] tbl_wr_param,
  input  wire logic [mpbs_pkg::EXT_SRC_W-1:0] ext_exec_source_select,
  input  wire logic [3:0]            ext_exec_inputs,
  input  wire logic                  motion_done,
  input  wire logic                  torque_reached,
  input  wire logic                  axis_standstill,
  output logic                       motion_start,
  output logic [mpbs_pkg::IDX_W-1:0] motion_block,
  output logic                       motion_fwd,
  output logic                       motion_rev,
  output logic                       motion_stopper,
  output logic                       motion_blend,
  output logic                       busy,
  output logic                       warn_active,
  output logic [15:0]                warn_code,
  output logic                       user_output_one,
  output logic                       user_output_two,
  output logic [15:0]                positioning_status_word_two
);
  import mpbs_pkg::*;

  // block table in flip-flops, indexed by block number
  mpbs_mode_t              mode_q [NUM_BLOCKS];
  mpbs_cond_t              cond_q [NUM_BLOCKS];
  logic [PARAM_W-1:0]      param_q [NUM_BLOCKS];

  mpbs_state_t             st_q, st_d;
  logic [IDX_W-1:0]        idx_q, idx_d;
  logic [PARAM_W-1:0]      ms_left_q, ms_left_d;
  logic [MS_CNT_W-1:0]     tick_q, tick_d;
  logic                    out1_q, out1_d, out2_q, out2_d;
  logic                    start_q, start_d, trig_q;
  logic                    fwd_q, fwd_d, rev_q, rev_d, stp_q, stp_d;
  logic                    blend_q, blend_d;
  logic                    warn_q, warn_d;

  mpbs_mode_t              cur_mode;
  mpbs_cond_t              cur_cond;
  logic [PARAM_W-1:0]      cur_param;
  logic                    ext_sig, launch, blk_done;
  logic [1:0]              cur_mask;

  // output parameter decode shared by set and reset modes
  function automatic logic [1:0] out_mask(input logic [PARAM_W-1:0] p);
    unique case (p[1:0])
      OUT_SEL_ONE:  out_mask = 2'b01;
      OUT_SEL_TWO:  out_mask = 2'b10;
      OUT_SEL_BOTH: out_mask = 2'b11;
      default:      out_mask = 2'b00;
    endcase
  endfunction

  assign cur_mode  = mode_q[idx_q];
  assign cur_cond  = cond_q[idx_q];
  assign cur_param = param_q[idx_q];
  // a select on a call result is refused by strict tools, so decode once
  assign cur_mask  = out_mask(cur_param);
  assign ext_sig   = ext_exec_inputs[ext_exec_source_select]; // RULE_11
  // launch only on a rising edge while program mode is selected
  assign launch    = block_launch_trigger && !trig_q &&
                     (positioning_operation_select == OPSEL_PROGRAM); // RULE_15

  // completion of the current block by its mode
  always_comb begin
    unique case (cur_mode)
      MODE_POSITION: blk_done = motion_done;
      MODE_STOPPER:  blk_done = torque_reached; // RULE_02
      MODE_FWD,
      MODE_REV:      blk_done = 1'b0; // endless; only an external-execution jump or reset ends it
      MODE_WAIT:     blk_done = (ms_left_q == '0); // RULE_04
      MODE_SWITCH,
      MODE_SET_IO,
      MODE_RESET_IO: blk_done = 1'b1;
    endcase
  end

  // sequencer next state
  always_comb begin
    st_d      = st_q;
    idx_d     = idx_q;
    ms_left_d = ms_left_q;
    tick_d    = tick_q;
    out1_d    = out1_q;
    out2_d    = out2_q;
    start_d   = 1'b0;
    fwd_d     = fwd_q;
    rev_d     = rev_q;
    stp_d     = stp_q;
    blend_d   = blend_q;
    warn_d    = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        fwd_d = 1'b0;
        rev_d = 1'b0;
        stp_d = 1'b0;
        if (launch) begin
          idx_d = block_select; // RULE_16
          st_d  = ST_NEXT;
        end
      end
      ST_NEXT: begin
        // enter block: latch mode-driven outputs
        st_d      = ST_RUN;
        start_d   = 1'b1;
        ms_left_d = cur_param;
        tick_d    = '0;
        fwd_d     = (cur_mode == MODE_FWD); // RULE_03
        rev_d     = (cur_mode == MODE_REV); // RULE_03
        stp_d     = (cur_mode == MODE_STOPPER); // RULE_02
        blend_d   = 1'b0;
        if (cur_mode == MODE_SET_IO) begin // RULE_06
          out1_d = out1_q | cur_mask[0];
          out2_d = out2_q | cur_mask[1];
        end else if (cur_mode == MODE_RESET_IO) begin // RULE_07
          out1_d = out1_q & ~cur_mask[0];
          out2_d = out2_q & ~cur_mask[1];
        end
      end
      ST_RUN: begin
        // millisecond base for the waiting mode
        if (cur_mode == MODE_WAIT && ms_left_q != '0) begin // RULE_04
          if (tick_q == MS_CNT_W'(MS_CYCLES - 1)) begin
            tick_d    = '0;
            ms_left_d = ms_left_q - PARAM_W'(1);
          end else begin
            tick_d = tick_q + MS_CNT_W'(1);
          end
        end
        if (cur_cond == COND_EXT_EXEC && ext_sig) begin // RULE_12
          idx_d   = idx_q + IDX_W'(1);
          blend_d = 1'b1;
          st_d    = ST_NEXT;
        end else if (blk_done) begin
          if (cur_mode == MODE_SWITCH) begin
            idx_d = cur_param[IDX_W-1:0]; // RULE_05
            st_d  = ST_NEXT;
          end else begin
            unique case (cur_cond)
              COND_FINISH:   st_d = ST_IDLE; // RULE_08
              COND_INTERMIT: st_d = ST_STOP; // RULE_09
              COND_CONTINUE,
              COND_EXT_EXEC: begin // RULE_10
                idx_d   = idx_q + IDX_W'(1);
                blend_d = 1'b1;
                st_d    = ST_NEXT;
              end
              COND_EXT_WAIT,
              COND_EXT_ALARM: st_d = ST_EXTW; // RULE_13
              default:        st_d = ST_IDLE;
            endcase
          end
        end
      end
      ST_STOP: begin
        if (axis_standstill) begin // RULE_09
          idx_d = idx_q + IDX_W'(1);
          st_d  = ST_NEXT;
        end
      end
      ST_EXTW: begin
        warn_d = (cur_cond == COND_EXT_ALARM) && !ext_sig; // RULE_14
        if (ext_sig) begin // RULE_13
          idx_d = idx_q + IDX_W'(1);
          st_d  = ST_NEXT;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q      <= ST_IDLE;
      idx_q     <= '0;
      ms_left_q <= '0;
      tick_q    <= '0;
      out1_q    <= 1'b0;
      out2_q    <= 1'b0;
      start_q   <= 1'b0;
      trig_q    <= 1'b0;
      fwd_q     <= 1'b0;
      rev_q     <= 1'b0;
      stp_q     <= 1'b0;
      blend_q   <= 1'b0;
      warn_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      idx_q     <= idx_d;
      ms_left_q <= ms_left_d;
      tick_q    <= tick_d;
      out1_q    <= out1_d;
      out2_q    <= out2_d;
      start_q   <= start_d;
      trig_q    <= block_launch_trigger;
      fwd_q     <= fwd_d;
      rev_q     <= rev_d;
      stp_q     <= stp_d;
      blend_q   <= blend_d;
      warn_q    <= warn_d;
    end
  end

  // table writes; entries reset to positioning with finish
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      if (!resetn) begin
        mode_q[i]  <= MODE_POSITION; // RULE_01
        cond_q[i]  <= COND_FINISH;
        param_q[i] <= '0;
      end else if (tbl_wr && tbl_wr_idx == IDX_W'(i)) begin
        mode_q[i]  <= tbl_wr_mode; // RULE_01
        cond_q[i]  <= tbl_wr_cond;
        param_q[i] <= tbl_wr_param;
      end
    end
  end

  assign motion_start    = start_q;
  assign motion_block    = idx_q;
  assign motion_fwd      = fwd_q;
  assign motion_rev      = rev_q;
  assign motion_stopper  = stp_q;
  assign motion_blend    = blend_q;
  assign busy            = (st_q != ST_IDLE);
  assign warn_active     = warn_q;
  assign warn_code       = warn_q ? WARN_EXT_WAIT : 16'h0000;
  assign user_output_one = out1_q;
  assign user_output_two = out2_q;
  // only the two user output bits are owned here
  always_comb begin
    positioning_status_word_two = 16'h0000;
    positioning_status_word_two[STW2_OUT1_BIT] = out1_q; // RULE_06
    positioning_status_word_two[STW2_OUT2_BIT] = out2_q; // RULE_07
  end

  // checks beside the logic
  a_finish_idle: assert property (@(posedge clk) disable iff (!resetn)
    st_q == ST_RUN && blk_done && cur_mode != MODE_SWITCH &&
    cur_cond == COND_FINISH && !(ext_sig && cur_cond == COND_EXT_EXEC)
    |=> st_q == ST_IDLE) // RULE_08
    else $error("finish did not stop");
  a_switch_target: assert property (@(posedge clk) disable iff (!resetn)
    st_q == ST_RUN && cur_mode == MODE_SWITCH && cur_cond != COND_EXT_EXEC
    |=> idx_q == $past(cur_param[IDX_W-1:0]) ##1 motion_start) // RULE_05
    else $error("switch target wrong");
  a_extw_hold: assert property (@(posedge clk) disable iff (!resetn)
    st_q == ST_EXTW && !ext_sig |=> st_q == ST_EXTW) // RULE_13
    else $error("external wait left early");
  a_alarm_warn: assert property (@(posedge clk) disable iff (!resetn)
    st_q == ST_EXTW && cur_cond == COND_EXT_ALARM && !ext_sig
    |=> warn_active && warn_code == WARN_EXT_WAIT) // RULE_14
    else $error("alarm warning missing");
  a_stop_wait: assert property (@(posedge clk) disable iff (!resetn)
    st_q == ST_STOP && !axis_standstill |=> !motion_start) // RULE_09
    else $error("intermittent did not wait");
  a_set_out: assert property (@(posedge clk) disable iff (!resetn)
    st_q == ST_NEXT && cur_mode == MODE_SET_IO && cur_param[1:0] == 2'h3
    |=> user_output_one && user_output_two) // RULE_06
    else $error("set outputs failed");
  a_reset_out: assert property (@(posedge clk) disable iff (!resetn)
    st_q == ST_NEXT && cur_mode == MODE_RESET_IO && cur_param[1:0] == 2'h1
    |=> !user_output_one && $stable(user_output_two)) // RULE_07
    else $error("reset outputs failed");
  a_launch_edge: assert property (@(posedge clk) disable iff (!resetn)
    st_q == ST_IDLE && launch |=> idx_q == $past(block_select)
    ##1 motion_start) // RULE_15
    else $error("launch not taken");
  a_dir_out: assert property (@(posedge clk) disable iff (!resetn) // RULE_03
    st_q == ST_NEXT && cur_mode == MODE_FWD |=> motion_fwd && !motion_rev)
    else $error("forward direction wrong");
  a_cont_blend: assert property (@(posedge clk) disable iff (!resetn)
    st_q == ST_RUN && blk_done && cur_mode != MODE_SWITCH &&
    cur_cond == COND_CONTINUE |=> motion_blend ##1 motion_start) // RULE_10
    else $error("continuous did not blend");
  c_launch:   cover property (@(posedge clk) launch);
  c_switch:   cover property (@(posedge clk)
    st_q == ST_RUN && cur_mode == MODE_SWITCH);
  c_ext_wait: cover property (@(posedge clk) st_q == ST_EXTW && ext_sig);
  c_wait_ms:  cover property (@(posedge clk)
    cur_mode == MODE_WAIT && st_q == ST_RUN && blk_done);
endmodule : mpbs_sequencer
`default_nettype wire

//--- mpbs_motion_model.sv
// file: motion core stand-in answering the sequencer's block starts
`timescale 1ns/1ps
`default_nettype none
module mpbs_motion_model #(
  parameter int DLY = 8
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic motion_start,
  input  wire logic motion_stopper,
  output logic      motion_done,
  output logic      torque_reached,
  output logic      axis_standstill
);
  logic [7:0] cnt_q;
  logic       run_q;

  // travel time counter, restarted by each block start
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
    end else if (motion_start) begin
      cnt_q <= 8'(DLY);
      run_q <= 1'b1;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // done drops in the start cycle so a stale level is never seen
  assign motion_done     = run_q && cnt_q == 8'h00 && !motion_start;
  assign torque_reached  = motion_done && motion_stopper;
  assign axis_standstill = motion_done;
endmodule // mpbs_motion_model
`default_nettype wire

//--- motion_program_block_sequencer_tb.sv
// file: self-checking bench of the program block sequencer
`timescale 1ns/1ps
`default_nettype none
module motion_program_block_sequencer_tb;
  import mpbs_pkg::*;
  logic        clk = 0, resetn = 0, trig = 0, wr = 0;
  logic [2:0]  opsel = 3'h0;
  logic [3:0]  sel = 4'h0, widx = 4'h0, ext = 4'h0, last_blk, blk;
  logic [1:0]  src = 2'h0;
  logic [15:0] wpar = 16'h0000, wcode, stw2;
  mpbs_mode_t  wmode = MODE_POSITION;
  mpbs_cond_t  wcond = COND_FINISH;
  logic        done, torq, still, start, fwd, rev, stop, warn, o1, o2;
  logic        blend;
  int          n_fail = 0, compares = 0, cyc = 0, n_start = 0;
  int          n_blend = 0;

  mpbs_sequencer u_dut (.clk(clk), .resetn(resetn),
    .positioning_operation_select(opsel), .block_select(sel),
    .block_launch_trigger(trig), .tbl_wr(wr), .tbl_wr_idx(widx),
    .tbl_wr_mode(wmode), .tbl_wr_cond(wcond), .tbl_wr_param(wpar),
    .ext_exec_source_select(src), .ext_exec_inputs(ext),
    .motion_done(done), .torque_reached(torq), .axis_standstill(still),
    .motion_start(start), .motion_block(blk), .motion_fwd(fwd),
    .motion_rev(rev), .motion_stopper(stop), .motion_blend(blend),
    .busy(), .warn_active(warn), .warn_code(wcode),
    .user_output_one(o1), .user_output_two(o2),
    .positioning_status_word_two(stw2));

  mpbs_motion_model u_core (.clk(clk), .resetn(resetn),
    .motion_start(start), .motion_stopper(stop), .motion_done(done),
    .torque_reached(torq), .axis_standstill(still));

  always #5 clk = ~clk;

  // start monitor on the far edge, clear of the design's updates
  always @(negedge clk) begin
    if (start === 1'b1) begin
      n_start++;
      last_blk = blk;
    end
    // blend is a one-cycle mark, so it is counted rather than sampled
    if (blend === 1'b1)
      n_blend++;
  end

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
  endtask

  task automatic wr_blk(input logic [3:0] i, input mpbs_mode_t m,
                        input mpbs_cond_t c, input logic [15:0] p);
    @(posedge clk);
    wr <= 1'b1;
    widx <= i;
    wmode <= m;
    wcond <= c;
    wpar <= p;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // host order: mode select and index first, then the rising edge
  task automatic launch(input logic [3:0] i, input logic [2:0] op);
    @(posedge clk);
    opsel <= op;
    sel <= i;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic run_idle(input logic [3:0] i);
    launch(i, OPSEL_PROGRAM);
    for (int k = 0; k < 300 && u_dut.busy !== 1'b0; k++) @(posedge clk);
    chk(16'(u_dut.busy), 16'h0000);
  endtask

  task automatic t_outputs();
    wr_blk(4'h0, MODE_SET_IO, COND_INTERMIT, 16'h0003);
    wr_blk(4'h1, MODE_RESET_IO, COND_FINISH, 16'h0001);
    wr_blk(4'h2, MODE_RESET_IO, COND_CONTINUE, 16'h0002);
    wr_blk(4'h3, MODE_SET_IO, COND_FINISH, 16'h0001);
    wr_blk(4'h4, MODE_RESET_IO, COND_FINISH, 16'h0003);
    run_idle(4'h0);
    chk(16'({o1, o2}), 16'h0001);
    chk(stw2, 16'h0800);
    run_idle(4'h2);
    chk(16'({o1, o2}), 16'h0002);
    chk(stw2, 16'h0400);
    run_idle(4'h4);
    chk(stw2, 16'h0000);
  endtask

  task automatic t_switch();
    int n0;
    wr_blk(4'h5, MODE_SWITCH, COND_CONTINUE, 16'h0009);
    wr_blk(4'h9, MODE_STOPPER, COND_FINISH, 16'h0000);
    run_idle(4'h5);
    chk(16'(last_blk), 16'h0009);
    n0 = n_start;
    repeat (30) @(posedge clk);
    chk(16'(n_start - n0), 16'h0000);
  endtask

  // the selected source stays low while the others sit high
  task automatic t_ext(input mpbs_cond_t c, input logic alarm);
    wr_blk(4'h6, MODE_POSITION, c, 16'h0000);
    wr_blk(4'h7, MODE_POSITION, COND_FINISH, 16'h0000);
    src <= 2'h2;
    ext <= 4'hb;
    launch(4'h6, OPSEL_PROGRAM);
    repeat (40) @(posedge clk);
    chk(16'(u_dut.busy), 16'h0001);
    chk(16'(last_blk), 16'h0006);
    chk(16'(warn), 16'(alarm));
    chk(wcode, alarm ? WARN_EXT_WAIT : 16'h0000);
    ext <= 4'hf;
    run_idle(4'h0);
    chk(16'(last_blk), 16'h0007);
    chk(16'(warn), 16'h0000);
    ext <= 4'h0;
  endtask

  task automatic t_refuse();
    int n0;
    n0 = n_start;
    launch(4'h7, 3'h1);
    repeat (20) @(posedge clk);
    chk(16'(n_start - n0), 16'h0000);
  endtask

  // zero wait, continuous, then an early jump by a source already high
  task automatic t_chain();
    int s0;
    int b0;
    wr_blk(4'hc, MODE_WAIT, COND_CONTINUE, 16'h0000);
    wr_blk(4'hd, MODE_POSITION, COND_EXT_EXEC, 16'h0000);
    wr_blk(4'he, MODE_POSITION, COND_FINISH, 16'h0000);
    src <= 2'h2;
    ext <= 4'h4;
    s0 = n_start;
    b0 = n_blend;
    run_idle(4'hc);
    chk(16'(last_blk), 16'h000e);
    chk(16'(n_start - s0), 16'h0003);
    chk(16'(n_blend - b0), 16'h0002);
    ext <= 4'h0;
  endtask

  task automatic t_dir(input mpbs_mode_t m, input logic [15:0] exp);
    do_reset();
    wr_blk(4'hb, m, COND_FINISH, 16'h0000);
    launch(4'hb, OPSEL_PROGRAM);
    repeat (30) @(posedge clk);
    chk(16'({fwd, rev}), exp);
    chk(16'(u_dut.busy), 16'h0001);
  endtask

  initial begin
    do_reset();
    t_outputs();
    t_switch();
    t_ext(COND_EXT_WAIT, 1'b0);
    t_ext(COND_EXT_ALARM, 1'b1);
    t_refuse();
    t_chain();
    t_dir(MODE_FWD, 16'h0002);
    t_dir(MODE_REV, 16'h0001);
    summarize();
  end
endmodule // motion_program_block_sequencer_tb
`default_nettype wire
